// ---- src/burst_cfg_regs.svh ----
`ifndef BURST_CFG_REGS_SVH
`define BURST_CFG_REGS_SVH

// Bit positions inside the 16-bit configuration word
`define CFG_READ_MODE_BIT      15
`define CFG_BIT14_POS          14
`define CFG_LATENCY_MSB        13
`define CFG_LATENCY_LSB        10
`define CFG_DATA_HOLD_BIT      9
`define CFG_WAIT_TIMING_BIT    8
`define CFG_BURST_ORDER_BIT    7
`define CFG_CLOCK_EDGE_BIT     6
`define CFG_BITS5_3_MSB        5
`define CFG_BITS5_3_LSB        3
`define CFG_BURST_LEN_MSB      2
`define CFG_BURST_LEN_LSB      0

// Value after power-up or hardware reset
`define CFG_RESET_VALUE        16'h9CC3

// Latency code 0 means this many clocks
`define CFG_LATENCY_BASE       4'h2
// Highest latency code with a defined meaning
`define CFG_LATENCY_MAX_CODE   4'h7

// Burst length codes
`define CFG_BL_TWO             3'h1
`define CFG_BL_FOUR            3'h2
`define CFG_BL_EIGHT           3'h3

`endif

// ---- src/burst_cfg_pkg.sv ----
package burst_cfg_pkg;

    // Field layout of the configuration word, MSB first
    typedef struct packed {
        logic       read_mode_select;
        logic       cfg_bit14;
        logic [3:0] initial_latency_code;
        logic       data_hold_config;
        logic       wait_indicator_timing;
        logic       burst_order_select;
        logic       clock_edge_select;
        logic [2:0] cfg_bits5_3;
        logic [2:0] burst_length_code;
    } cfg_word_t;

    // Host-side register command group, link clock domain
    typedef struct packed {
        logic        cfg_write;
        logic [15:0] cfg_wdata;
        logic        cfg_read_cmd;
        logic        cfg_read_bank;
        logic        id_exit;
        logic        read;
        logic        read_bank;
    } cfg_cmd_t;

    // Burst pin group, link clock domain
    typedef struct packed {
        logic       address_valid_n;
        logic       chip_enable_n;
        logic       output_enable_n;
        logic [2:0] start_addr;
    } burst_pins_t;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_LATENCY,
        BURST_DATA
    } burst_state_t;

endpackage : burst_cfg_pkg

// ---- src/burst_config_register.sv ----
// Notes on behaviour
// [R1] Reset enters asynchronous read mode and loads every field default.
// [R2] Host writes the whole register before any burst read.
// [R3] Chip enable high leaves the register contents untouched.
// [R4] Register has no array address; reached only via configuration commands.
// [R5] Register readable at all times, even during program or erase.
// [R6] Writes during program or erase are dropped, contents unchanged.
// [R7] Sixteen bits on low data lines; high data lines read zero.
// [R8] Read command latches bank; that bank reads register, other bank reads array.
// [R9] Four-cycle host sequence; reads handled like identification-mode reads.
// [R10] Bit 15: 0 synchronous burst, 1 asynchronous; default 1.
// [R11] Bits 13..10 latency: codes 0..7 give 2..9 clocks; default 7.
// [R12] Bit 9: 0 holds each word one clock; 1 reserved.
// [R13] Bit 8: 0 flag on last transfer; 1 one transfer earlier.
// [R14] Bit 7: 1 linear order (default); 0 reserved.
// [R15] Bit 6: 1 rising-edge start and output (default); 0 reserved.
// [R16] Host writes zero to bit 14 and bits 5..3.
// [R17] Bits 2..0: 001 two, 010 four, 011 eight words; others no burst.
// [R18] Burst length resets to code 011, eight double words.
// [R19] Hardware reset ends a burst at once, floats bus, restores defaults.
// [R20] End-of-burst flag low one clock on last or second-to-last transfer.
// [R21] Linear burst reads aligned group of configured size, wrapping around.
// [R22] Burst length code 111 disables bursts like other reserved codes.
`include "burst_cfg_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module burst_config_register #(
    parameter int BUS_W = 32
) (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        burst_clk_in,
    input  wire logic                        algo_busy_in,
    input  wire burst_cfg_pkg::cfg_cmd_t     cmd_in,
    input  wire logic [BUS_W-1:0]            array_data_in,
    input  wire burst_cfg_pkg::burst_pins_t  pins_in,
    output logic [BUS_W-1:0]                 rd_data_out,
    output logic                             rd_is_cfg_out,
    output logic                             rd_valid_out,
    output burst_cfg_pkg::cfg_word_t         cfg_out,
    output logic                             burst_valid_out,
    output logic [2:0]                       burst_word_out,
    output logic                             data_oe_out,
    output logic                             end_of_burst_flag_n_out,
    output logic                             end_of_burst_flag_oe_out,
    output logic                             sync_mode_core_out,
    output logic                             cfg_write_dropped_out
);
    import burst_cfg_pkg::*;

    initial begin
        if (BUS_W != 32) begin
            $error("burst_config_register: BUS_W must be 32");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: busy level and dropped-write event
    ////////////////////////////////////////////////////////////////////////////
    logic busy_core_ff;
    logic drop_meta_ff;
    logic drop_sync_ff;
    logic drop_seen_ff;
    logic mode_meta_ff;
    logic mode_sync_ff;
    logic drop_tgl_ff;

    // Launch busy from a flop so the link side samples a clean level
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_core_ff <= 1'b0;
        end else begin
            busy_core_ff <= algo_busy_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            drop_meta_ff          <= 1'b0;
            drop_sync_ff          <= 1'b0;
            drop_seen_ff          <= 1'b0;
            cfg_write_dropped_out <= 1'b0;
        end else begin
            drop_meta_ff          <= drop_tgl_ff;
            drop_sync_ff          <= drop_meta_ff;
            drop_seen_ff          <= drop_sync_ff;
            cfg_write_dropped_out <= drop_sync_ff ^ drop_seen_ff;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_meta_ff       <= 1'b0;
            mode_sync_ff       <= 1'b0;
            sync_mode_core_out <= 1'b0;
        end else begin
            mode_meta_ff       <= ~cfg_out.read_mode_select;
            mode_sync_ff       <= mode_meta_ff;
            sync_mode_core_out <= mode_sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: configuration register
    ////////////////////////////////////////////////////////////////////////////
    logic busy_meta_ff;
    logic busy_sync_ff;

    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_meta_ff <= 1'b0;
            busy_sync_ff <= 1'b0;
        end else begin
            busy_meta_ff <= busy_core_ff;
            busy_sync_ff <= busy_meta_ff;
        end
    end

    // Chip enable is deliberately absent here so contents persist
    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_out <= cfg_word_t'(`CFG_RESET_VALUE); // [R1] [R18] [R19]
        end else if (cmd_in.cfg_write && !busy_sync_ff) begin
            // Stored as written; reserved codes only act as burst disable
            cfg_out <= cfg_word_t'(cmd_in.cfg_wdata); // [R3] [R16]
        end
    end

    // Dropped write reported to the core side as a toggle
    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            drop_tgl_ff <= 1'b0;
        end else if (cmd_in.cfg_write && busy_sync_ff) begin
            drop_tgl_ff <= ~drop_tgl_ff; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: configuration read mode and read data
    ////////////////////////////////////////////////////////////////////////////
    logic id_mode_ff;
    logic id_bank_ff;
    logic hit_cfg;

    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            id_mode_ff <= 1'b0;
            id_bank_ff <= 1'b0;
        end else if (cmd_in.cfg_read_cmd) begin
            id_mode_ff <= 1'b1; // [R9]
            id_bank_ff <= cmd_in.cfg_read_bank; // [R8]
        end else if (cmd_in.id_exit) begin
            id_mode_ff <= 1'b0;
        end
    end

    // Only the latched bank in read mode sees the register
    assign hit_cfg = id_mode_ff && (cmd_in.read_bank == id_bank_ff); // [R4] [R8]

    // Busy does not gate reads
    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out   <= '0;
            rd_is_cfg_out <= 1'b0;
            rd_valid_out  <= 1'b0;
        end else begin
            rd_valid_out <= cmd_in.read; // [R5]
            if (cmd_in.read) begin
                rd_is_cfg_out <= hit_cfg;
                if (hit_cfg) begin
                    rd_data_out <= {{(BUS_W-16){1'b0}}, 16'(cfg_out)}; // [R7]
                end else begin
                    rd_data_out <= array_data_in;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: burst sequencer
    ////////////////////////////////////////////////////////////////////////////
    burst_state_t state_ff;
    burst_state_t nxt_state;
    logic [3:0]   lat_cnt_ff;
    logic [3:0]   nxt_lat_cnt;
    logic [2:0]   start_ff;
    logic [2:0]   nxt_start;
    logic [2:0]   beat_ff;
    logic [2:0]   nxt_beat;
    logic [2:0]   len_mask;
    logic [2:0]   last_beat;
    logic [2:0]   flag_beat;
    logic         burst_ok;
    logic [3:0]   lat_total;
    logic         nxt_valid;
    logic [2:0]   nxt_word;
    logic         nxt_flag_n;

    // Decode of length; every other code means asynchronous only
    always_comb begin
        len_mask = 3'h0;
        burst_ok = 1'b1;
        unique case (cfg_out.burst_length_code) // [R17] [R22]
            `CFG_BL_TWO:   len_mask = 3'h1;
            `CFG_BL_FOUR:  len_mask = 3'h3;
            `CFG_BL_EIGHT: len_mask = 3'h7;
            default:       burst_ok = 1'b0;
        endcase
    end

    // Reserved values of bits 9, 7, 6 and latency codes above 7 refuse bursts
    logic sync_enabled;
    assign sync_enabled = !cfg_out.read_mode_select && burst_ok // [R10]
                        && !cfg_out.data_hold_config            // [R12]
                        && cfg_out.burst_order_select           // [R14]
                        && cfg_out.clock_edge_select            // [R15]
                        && (cfg_out.initial_latency_code <= `CFG_LATENCY_MAX_CODE);

    assign lat_total = cfg_out.initial_latency_code + `CFG_LATENCY_BASE; // [R11]
    assign last_beat = len_mask;
    // Second-to-last option moves the flag one transfer earlier
    assign flag_beat = cfg_out.wait_indicator_timing ? 3'(last_beat - 3'h1)
                                                     : last_beat; // [R13] [R20]

    always_comb begin
        nxt_state   = state_ff;
        nxt_lat_cnt = lat_cnt_ff;
        nxt_start   = start_ff;
        nxt_beat    = beat_ff;
        nxt_valid   = 1'b0;
        if (pins_in.chip_enable_n) begin
            nxt_state = BURST_IDLE;
        end else if (!pins_in.address_valid_n) begin
            // A fresh address valid pulse abandons any burst in flight
            if (sync_enabled) begin
                nxt_state   = BURST_LATENCY;
                nxt_lat_cnt = 4'(lat_total - 4'h1);
                nxt_start   = pins_in.start_addr;
                nxt_beat    = 3'h0;
            end else begin
                nxt_state = BURST_IDLE;
            end
        end else begin
            unique case (state_ff)
                BURST_IDLE: begin
                    nxt_state = BURST_IDLE;
                end
                BURST_LATENCY: begin
                    if (lat_cnt_ff == 4'h1) begin
                        nxt_state = BURST_DATA;
                        nxt_beat  = 3'h0;
                        nxt_valid = 1'b1;
                    end else begin
                        nxt_lat_cnt = 4'(lat_cnt_ff - 4'h1);
                    end
                end
                BURST_DATA: begin
                    // Keeps clocking past the last word: wraps to the start
                    nxt_beat  = 3'(beat_ff + 3'h1) & len_mask; // [R21]
                    nxt_valid = 1'b1;
                end
            endcase
        end
    end

    // Word index walks within the aligned group of the start address
    assign nxt_word   = (nxt_start & ~len_mask)
                      | (3'(nxt_start + nxt_beat) & len_mask); // [R21]
    assign nxt_flag_n = !(nxt_valid && (nxt_beat == flag_beat)); // [R20]

    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff   <= BURST_IDLE; // [R19]
            lat_cnt_ff <= 4'h0;
            start_ff   <= 3'h0;
            beat_ff    <= 3'h0;
        end else begin
            state_ff   <= nxt_state;
            lat_cnt_ff <= nxt_lat_cnt;
            start_ff   <= nxt_start;
            beat_ff    <= nxt_beat;
        end
    end

    // Output enable floats pins but never halts the sequence
    always_ff @(posedge burst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            burst_valid_out          <= 1'b0; // [R19]
            burst_word_out           <= 3'h0;
            data_oe_out              <= 1'b0;
            end_of_burst_flag_n_out  <= 1'b1;
            end_of_burst_flag_oe_out <= 1'b0;
        end else begin
            burst_valid_out          <= nxt_valid;
            burst_word_out           <= nxt_valid ? nxt_word : 3'h0;
            data_oe_out              <= nxt_valid && !pins_in.output_enable_n;
            end_of_burst_flag_n_out  <= nxt_flag_n;
            end_of_burst_flag_oe_out <= (nxt_state != BURST_IDLE)
                                        && !pins_in.output_enable_n;
        end
    end

endmodule : burst_config_register

`default_nettype wire

// ---- testbench/burst_cfg_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module burst_cfg_props #(
    parameter int BUS_W = 32
) (
    input wire logic                       clk_in,
    input wire logic                       rstn_in,
    input wire logic                       burst_clk_in,
    input wire burst_cfg_pkg::cfg_cmd_t    cmd_in,
    input wire logic [BUS_W-1:0]           array_data_in,
    input wire burst_cfg_pkg::burst_pins_t pins_in,
    input wire logic [BUS_W-1:0]           rd_data_out,
    input wire logic                       rd_is_cfg_out,
    input wire logic                       rd_valid_out,
    input wire burst_cfg_pkg::cfg_word_t   cfg_out,
    input wire logic                       burst_valid_out,
    input wire logic [2:0]                 burst_word_out,
    input wire logic                       end_of_burst_flag_n_out,
    input wire logic                       cfg_write_dropped_out
);
    import burst_cfg_pkg::*;

    a_reset_default: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> cfg_out == 16'h9CC3) else $error("config not at default");
    a_cfg_hold: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        !cmd_in.cfg_write |=> $stable(cfg_out)) else $error("config changed without write");
    a_read_pulse: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        rd_valid_out == $past(cmd_in.read)) else $error("read answer not one cycle later");
    a_upper_zero: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        rd_valid_out && rd_is_cfg_out |-> rd_data_out[BUS_W-1:16] == '0)
        else $error("upper lines not zero");
    a_array_pass: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        cmd_in.read ##1 (rd_valid_out && !rd_is_cfg_out) |-> rd_data_out == $past(array_data_in))
        else $error("array data not passed");
    a_cfg_value: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        cmd_in.read ##1 rd_is_cfg_out |-> rd_data_out[15:0] == $past(cfg_out))
        else $error("config read value wrong");
    a_no_burst: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        !pins_in.address_valid_n && !pins_in.chip_enable_n && cfg_out.read_mode_select
        |-> ##2 (!burst_valid_out) [*4]) else $error("burst in asynchronous mode");
    a_flag_once: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        $fell(end_of_burst_flag_n_out) |=> end_of_burst_flag_n_out) else $error("flag too long");
    a_word_step: assert property (@(posedge burst_clk_in) disable iff (!rstn_in)
        burst_valid_out ##1 burst_valid_out |-> burst_word_out != $past(burst_word_out))
        else $error("burst word held");
    a_drop_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cfg_write_dropped_out |=> !cfg_write_dropped_out) else $error("drop pulse too long");
endmodule : burst_cfg_props

bind burst_config_register burst_cfg_props #(.BUS_W(BUS_W)) props_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .burst_clk_in(burst_clk_in), .cmd_in(cmd_in),
    .array_data_in(array_data_in), .pins_in(pins_in), .rd_data_out(rd_data_out),
    .rd_is_cfg_out(rd_is_cfg_out), .rd_valid_out(rd_valid_out), .cfg_out(cfg_out),
    .burst_valid_out(burst_valid_out), .burst_word_out(burst_word_out),
    .end_of_burst_flag_n_out(end_of_burst_flag_n_out),
    .cfg_write_dropped_out(cfg_write_dropped_out));

`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic                      burst_clk_in,
    output var burst_cfg_pkg::cfg_cmd_t    cmd_out,
    output var burst_cfg_pkg::burst_pins_t pins_out
);
    import burst_cfg_pkg::*;

    initial begin
        cmd_out = '0;
        pins_out = burst_pins_t'(6'h38);
    end

    task automatic step();
        @(posedge burst_clk_in);
        #1;
    endtask : step

    // Write data bus is inverted once released so a stale value never passes
    task automatic wr(input logic [15:0] d);
        step();
        cmd_out.cfg_write = 1'b1;
        cmd_out.cfg_wdata = d & 16'hBFC7;
        step();
        cmd_out.cfg_write = 1'b0;
        cmd_out.cfg_wdata = ~cmd_out.cfg_wdata;
    endtask : wr

    // Final decoded cycle of the four-cycle read sequence
    task automatic cmd(input logic rc, input logic ex, input logic rd, input logic bk);
        step();
        {cmd_out.cfg_read_cmd, cmd_out.id_exit, cmd_out.read} = {rc, ex, rd};
        {cmd_out.cfg_read_bank, cmd_out.read_bank} = {bk, bk};
        step();
        {cmd_out.cfg_read_cmd, cmd_out.id_exit, cmd_out.read} = 3'h0;
        {cmd_out.cfg_read_bank, cmd_out.read_bank} = {~bk, ~bk};
    endtask : cmd

    task automatic pins(input logic [5:0] p);
        step();
        pins_out = burst_pins_t'(p);
    endtask : pins
endmodule : host_model

`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    import burst_cfg_pkg::*;
    logic        clk_in, burst_clk, rstn_in, algo_busy_in;
    logic [31:0] arr, rd_data;
    cfg_cmd_t    cmd;
    burst_pins_t pins;
    cfg_word_t   cfg;
    logic        rd_is_cfg, rd_valid, bv, doe, flag_n, flag_oe, sync_core, dropped;
    logic [2:0]  word;
    int          n_errors = 0;
    int          checks = 0;

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        burst_clk = 1'b0;
        #3;
        forever #6 burst_clk = ~burst_clk;
    end

    host_model host_u (.burst_clk_in(burst_clk), .cmd_out(cmd), .pins_out(pins));
    burst_config_register dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .burst_clk_in(burst_clk),
        .algo_busy_in(algo_busy_in), .cmd_in(cmd), .array_data_in(arr), .pins_in(pins),
        .rd_data_out(rd_data), .rd_is_cfg_out(rd_is_cfg), .rd_valid_out(rd_valid),
        .cfg_out(cfg), .burst_valid_out(bv), .burst_word_out(word), .data_oe_out(doe),
        .end_of_burst_flag_n_out(flag_n), .end_of_burst_flag_oe_out(flag_oe),
        .sync_mode_core_out(sync_core), .cfg_write_dropped_out(dropped));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic bstep(input int n);
        repeat (n) @(posedge burst_clk);
        #1;
    endtask : bstep

    task automatic cstep(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cstep

    task automatic do_reset();
        rstn_in = 1'b0;
        cstep(6);
        rstn_in = 1'b1;
        bstep(2);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regread();
        host_u.cmd(0, 0, 1, 1);
        chk("unmapped", arr, rd_data);
        host_u.cmd(1, 0, 0, 1);
        host_u.cmd(0, 0, 1, 1);
        chk("cfg read", {15'h0, rd_is_cfg, 16'h9CC3}, {15'h0, 1'b1, rd_data[15:0]});
        chk("upper", 32'h0, {16'h0, rd_data[31:16]});
        arr = 32'h0F1E_2D3C;
        host_u.cmd(0, 0, 1, 0);
        chk("other bank", 32'h0F1E_2D3C, rd_data);
        host_u.wr(16'h04C2);
        host_u.cmd(0, 0, 1, 1);
        chk("readback", 32'h0000_04C2, rd_data);
        cstep(4);
        chk("sync mode", 32'h1, {31'h0, sync_core});
        host_u.cmd(0, 1, 0, 0);
        arr = 32'h8421_7BDE;
        host_u.cmd(0, 0, 1, 1);
        chk("after exit", 32'h8421_7BDE, rd_data);
        $display("test regread done");
    endtask : t_regread

    task automatic t_busy();
        logic seen;
        seen = 1'b0;
        cstep(1);
        algo_busy_in = 1'b1;
        cstep(3);
        host_u.wr(16'h8C83);
        repeat (10) begin
            cstep(1);
            seen = seen | (dropped === 1'b1);
        end
        chk("drop pulse", 32'h1, {31'h0, seen});
        chk("cfg kept", 32'h04C2, {16'h0, cfg});
        host_u.cmd(1, 0, 0, 0);
        host_u.cmd(0, 0, 1, 0);
        chk("busy read", 32'h04C2, rd_data);
        host_u.cmd(0, 1, 0, 0);
        cstep(1);
        algo_busy_in = 1'b0;
        cstep(3);
        $display("test busy done");
    endtask : t_busy

    task automatic t_burst(input logic [3:0] lat, input logic wt, input logic [2:0] lc,
                           input logic [2:0] s);
        logic [2:0] m;
        logic [2:0] b;
        m = 3'((4'h1 << lc) - 4'h1);
        host_u.wr({2'b00, lat, 1'b0, wt, 2'b11, 3'b000, lc});
        host_u.pins({3'b000, s});
        host_u.pins({3'b100, s});
        bstep(int'(lat));
        chk("latency", 32'h0, {31'h0, bv});
        for (int i = 0; i < 2 * (int'(m) + 1); i++) begin
            bstep(1);
            b = 3'(s + 3'(i));
            chk("word", {26'h0, 3'b111, (s & ~m) | (b & m)}, {26'h0, flag_oe, bv, doe, word});
            chk("flag", {31'h0, (3'(i) & m) != (wt ? m - 3'h1 : m)}, {31'h0, flag_n});
        end
        host_u.pins({3'b111, ~s});
        bstep(1);
        chk("ce exit", {16'h0, cfg}, {15'h0, bv, {2'b00, lat, 1'b0, wt, 5'h18, lc}});
        $display("test burst done");
    endtask : t_burst

    task automatic t_noburst();
        logic [15:0] tbl [9] = '{16'h04C0, 16'h04C4, 16'h04C5, 16'h04C6, 16'h04C7,
                                 16'h84C2, 16'h0442, 16'h0482, 16'h06C2};
        logic        v;
        foreach (tbl[k]) begin
            v = 1'b0;
            host_u.wr(tbl[k]);
            host_u.pins(6'h01);
            host_u.pins(6'h21);
            repeat (12) begin
                bstep(1);
                v = v | (bv !== 1'b0);
            end
            chk("no burst", 32'h0, {31'h0, v});
            host_u.pins(6'h38);
        end
        $display("test noburst done");
    endtask : t_noburst

    task automatic t_reset_mid();
        host_u.wr(16'h04C3);
        host_u.pins(6'h02);
        host_u.pins(6'h22);
        bstep(4);
        rstn_in = 1'b0;
        #1;
        chk("reset stop", {13'h1, 16'h9CC3}, {13'h0, bv, doe, flag_n, cfg});
        host_u.pins(6'h38);
        do_reset();
        chk("after reset", {15'h0, 1'b0, 16'h9CC3}, {15'h0, sync_core, cfg});
        $display("test reset_mid done");
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn_in = 1'b0;
        algo_busy_in = 1'b0;
        arr = 32'hC3A5_5A3C;
        do_reset();
        t_regread();
        t_busy();
        t_burst(4'h1, 1'b0, 3'h2, 3'h1);
        t_burst(4'h0, 1'b1, 3'h3, 3'h6);
        t_burst(4'h7, 1'b0, 3'h1, 3'h1);
        t_noburst();
        t_reset_mid();
        conclude();
    end

    // Whole sequence takes well under 30 us
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule : tb

`default_nettype wire
